// File: hdl/trip_logic.sv
// Phase-selective trip decision logic with APB settings and event registers
//
// Behaviour
// - The mode is off, three-phase only, or single/three-phase, and is off after reset.
// - A minimum pulse setting of 50 to 60000 ms in 1 ms steps resets to 150 ms.
// - Trip outputs set when a trip starts stay on for at least the minimum pulse time, unless suppress, a clear or mode off ends it.
// - An evolving-fault wait setting of 50 to 60000 ms in 1 ms steps resets to 1000 ms.
// - Any request while the evolving-fault wait runs after a trip trips all three phases.
// - Requests on two phases at once also trip the third phase.
// - While the force input is high a single-phase fault trips all three phases.
// - While the suppress input is high every trip output is off.
// - In single/three-phase mode a request on one phase alone trips only that phase.
// - The general trip is on whenever any phase trip is on.
// - Outputs are one trip per phase, a three-pole trip and a general trip.
// - Each phase trip and the general trip report an on and an off event.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module trip_logic #(
   parameter int TICK_CYCLES = trip_pkg::TICK_CYCLES,
   parameter int MS_W = trip_pkg::MS_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [trip_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trip_suppress_in,
   input wire logic single_pole_request_in,
   input wire logic three_pole_request_in,
   input wire logic phase_a_request_in,
   input wire logic phase_b_request_in,
   input wire logic phase_c_request_in,
   input wire logic force_three_pole_in,
   output logic phase_a_trip_out,
   output logic phase_b_trip_out,
   output logic phase_c_trip_out,
   output logic general_trip_out,
   output logic three_pole_trip_out
);

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   if (TICK_CYCLES < 2)
   begin : g_bad_tick
      $error("trip_logic: TICK_CYCLES must be at least 2");
   end
   if (MS_W < 16)
   begin : g_bad_ms
      $error("trip_logic: MS_W must hold 60000");
   end

   localparam int TICK_W = $clog2(TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic logic two_or_more(input logic [2:0] ph);
      two_or_more = (ph[0] & ph[1]) | (ph[1] & ph[2]) | (ph[0] & ph[2]);
   endfunction : two_or_more

   function automatic logic in_range(input logic [15:0] ms);
      in_range = (ms >= trip_pkg::SET_MIN_MS) && (ms <= trip_pkg::SET_MAX_MS);
   endfunction : in_range

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [trip_pkg::REQ_N-1:0] raw_in;
   logic [trip_pkg::REQ_N-1:0] sync1_r;
   logic [trip_pkg::REQ_N-1:0] sync2_r;
   logic [trip_pkg::REQ_N-1:0] sync3_r;
   logic [trip_pkg::REQ_N-1:0] filt_r;

   assign raw_in[trip_pkg::REQ_A] = phase_a_request_in;
   assign raw_in[trip_pkg::REQ_B] = phase_b_request_in;
   assign raw_in[trip_pkg::REQ_C] = phase_c_request_in;
   assign raw_in[trip_pkg::REQ_SINGLE] = single_pole_request_in;
   assign raw_in[trip_pkg::REQ_THREE] = three_pole_request_in;
   assign raw_in[trip_pkg::REQ_FORCE] = force_three_pole_in;
   assign raw_in[trip_pkg::REQ_SUPP] = trip_suppress_in;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         filt_r <= '0;
      end
      else
      begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
      end
   end

   // ****************************************************************
   // Millisecond tick
   // ****************************************************************
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= (tick_cnt_r == TICK_LAST);
         tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + TICK_W'(1);
      end
   end

   // ****************************************************************
   // APB access
   // ****************************************************************
   trip_pkg::mode_t mode_r;
   logic [15:0] pulse_ms_r;
   logic [15:0] evolve_ms_r;
   logic [2*trip_pkg::EV_N-1:0] event_r;
   logic clr_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic setup;
   logic wr;
   logic mapped;
   logic [31:0] status_word;
   logic pulse_run;
   logic evolve_run;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pready_r & pwrite;
   assign mapped = (paddr == trip_pkg::CTRL_OFS) || (paddr == trip_pkg::PULSE_OFS) ||
                   (paddr == trip_pkg::EVOLVE_OFS) || (paddr == trip_pkg::STATUS_OFS) ||
                   (paddr == trip_pkg::EVENT_OFS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= 32'h0000_0000;
      end
      else if (setup && !pwrite)
      begin
         unique case (paddr)
            trip_pkg::CTRL_OFS: prdata_r <= {30'h0000_0000, mode_r};
            trip_pkg::PULSE_OFS: prdata_r <= {16'h0000, pulse_ms_r};
            trip_pkg::EVOLVE_OFS: prdata_r <= {16'h0000, evolve_ms_r};
            trip_pkg::STATUS_OFS: prdata_r <= status_word;
            trip_pkg::EVENT_OFS: prdata_r <= {24'h00_0000, event_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************************************
   // Settings
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= trip_pkg::MODE_OFF;
      end
      else if (wr && (paddr == trip_pkg::CTRL_OFS) &&
               (pwdata[1:0] != 2'h3))
      begin
         mode_r <= trip_pkg::mode_t'(pwdata[1:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pulse_ms_r <= trip_pkg::PULSE_RST_MS;
         evolve_ms_r <= trip_pkg::EVOLVE_RST_MS;
      end
      else if (wr)
      begin
         if ((paddr == trip_pkg::PULSE_OFS) && in_range(pwdata[15:0]))
         begin
            pulse_ms_r <= pwdata[15:0];
         end
         if ((paddr == trip_pkg::EVOLVE_OFS) && in_range(pwdata[15:0]))
         begin
            evolve_ms_r <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clr_r <= 1'b0;
      end
      else
      begin
         clr_r <= wr && (paddr == trip_pkg::CTRL_OFS) && pwdata[trip_pkg::CTRL_CLR_BIT];
      end
   end

   // ****************************************************************
   // Trip decision
   // ****************************************************************
   logic [2:0] req_ph;
   logic req_any;
   logic enabled;
   logic widen;
   logic new_phase;
   logic [2:0] cand;
   logic active_r;
   logic active_nxt;
   logic [2:0] latch_r;
   logic [2:0] latch_nxt;
   logic three_r;
   logic gen_r;
   logic three_nxt;
   logic gen_nxt;
   logic pulse_load;
   logic evolve_load;

   assign req_ph = {filt_r[trip_pkg::REQ_C], filt_r[trip_pkg::REQ_B],
                    filt_r[trip_pkg::REQ_A]};
   assign req_any = (|req_ph) | filt_r[trip_pkg::REQ_SINGLE] |
                    filt_r[trip_pkg::REQ_THREE];
   assign enabled = (mode_r != trip_pkg::MODE_OFF) && !filt_r[trip_pkg::REQ_SUPP]
                    && !clr_r;
   assign new_phase = active_r && (|(req_ph & ~latch_r));

   always_comb
   begin
      widen = filt_r[trip_pkg::REQ_THREE]
              | filt_r[trip_pkg::REQ_FORCE]
              | two_or_more(req_ph)
              | (filt_r[trip_pkg::REQ_SINGLE] && (req_ph == 3'b000))
              | evolve_run
              | new_phase;
      if (!req_any)
      begin
         cand = 3'b000;
      end
      else if (mode_r == trip_pkg::MODE_THREE)
      begin
         cand = 3'b111;
      end
      else if (widen)
      begin
         cand = 3'b111;
      end
      else
      begin
         cand = req_ph;
      end
   end

   assign active_nxt = enabled && (req_any || (active_r && pulse_run));
   assign latch_nxt = active_nxt ? (latch_r | cand) : 3'b000;
   assign three_nxt = &latch_nxt;
   assign gen_nxt = |latch_nxt;
   assign pulse_load = enabled && req_any && !active_r;
   assign evolve_load = enabled && active_r && !active_nxt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_r <= 1'b0;
         latch_r <= 3'b000;
         three_r <= 1'b0;
         gen_r <= 1'b0;
      end
      else
      begin
         active_r <= active_nxt;
         latch_r <= latch_nxt;
         three_r <= three_nxt;
         gen_r <= gen_nxt;
      end
   end

   assign phase_a_trip_out = latch_r[0];
   assign phase_b_trip_out = latch_r[1];
   assign phase_c_trip_out = latch_r[2];
   assign three_pole_trip_out = three_r;
   assign general_trip_out = gen_r;

   // ****************************************************************
   // Timers
   // ****************************************************************
   ms_timer #(
      .CNT_W(MS_W)
   ) u_pulse_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clr(clr_r),
      .load(pulse_load),
      .load_val(MS_W'(pulse_ms_r + trip_pkg::ONE_MS)),
      .tick(tick_r),
      .running(pulse_run)
   );

   ms_timer #(
      .CNT_W(MS_W)
   ) u_evolve_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clr(clr_r || (mode_r == trip_pkg::MODE_OFF)),
      .load(evolve_load),
      .load_val(MS_W'(evolve_ms_r + trip_pkg::ONE_MS)),
      .tick(tick_r),
      .running(evolve_run)
   );

   // ****************************************************************
   // Events and status
   // ****************************************************************
   logic [trip_pkg::EV_N-1:0] out_now;
   logic [trip_pkg::EV_N-1:0] out_nxt;
   logic [2*trip_pkg::EV_N-1:0] ev_set;
   logic [2*trip_pkg::EV_N-1:0] ev_clr;

   assign out_now = {gen_r, latch_r};
   assign out_nxt = {gen_nxt, latch_nxt};
   assign ev_set = {out_now & ~out_nxt, out_nxt & ~out_now};
   assign ev_clr = (wr && (paddr == trip_pkg::EVENT_OFS)) ?
                   pwdata[2*trip_pkg::EV_N-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         event_r <= '0;
      end
      else
      begin
         event_r <= (event_r & ~ev_clr) | ev_set;
      end
   end

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[2:0] = latch_r;
      status_word[3] = three_r;
      status_word[4] = gen_r;
      status_word[trip_pkg::ST_PULSE_BIT] = pulse_run;
      status_word[trip_pkg::ST_EVOLVE_BIT] = evolve_run;
      status_word[trip_pkg::ST_SUPP_BIT] = filt_r[trip_pkg::REQ_SUPP];
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

endmodule : trip_logic
`default_nettype wire

// File: shared/trip_pkg.sv
// Constants, register map and types of the phase-selective trip logic
package trip_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1_000_000;
   localparam int TICK_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_W = 16;

   // ****************************************************************
   // Setting ranges in milliseconds
   // ****************************************************************
   localparam logic [15:0] SET_MIN_MS = 16'h0032;
   localparam logic [15:0] SET_MAX_MS = 16'hEA60;
   localparam logic [15:0] PULSE_RST_MS = 16'h0096;
   localparam logic [15:0] EVOLVE_RST_MS = 16'h03E8;
   localparam logic [15:0] ONE_MS = 16'h0001;

   // ****************************************************************
   // Operating modes
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_THREE = 2'h1,
      MODE_SELECT = 2'h2
   } mode_t;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] PULSE_OFS = 12'h004;
   localparam logic [11:0] EVOLVE_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00C;
   localparam logic [11:0] EVENT_OFS = 12'h010;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_CLR_BIT = 8;
   localparam int ST_PULSE_BIT = 5;
   localparam int ST_EVOLVE_BIT = 6;
   localparam int ST_SUPP_BIT = 7;
   localparam int EV_ON_LSB = 0;
   localparam int EV_OFF_LSB = 4;
   localparam int EV_N = 4;

   // ****************************************************************
   // Request input indices
   // ****************************************************************
   localparam int REQ_A = 0;
   localparam int REQ_B = 1;
   localparam int REQ_C = 2;
   localparam int REQ_SINGLE = 3;
   localparam int REQ_THREE = 4;
   localparam int REQ_FORCE = 5;
   localparam int REQ_SUPP = 6;
   localparam int REQ_N = 7;

endpackage : trip_pkg

// File: hdl/ms_timer.sv
// Millisecond down-counter used for pulse and evolving-fault timing
`timescale 1ns/100ps
`default_nettype none
module ms_timer #(
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_val,
   input wire logic tick,
   output logic running
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (CNT_W < 2)
   begin : g_bad_width
      $error("ms_timer: CNT_W too small");
   end

   // ****************************************************************
   // Counter
   // ****************************************************************
   logic [CNT_W-1:0] count_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_r <= '0;
      end
      else if (clr)
      begin
         count_r <= '0;
      end
      else if (load)
      begin
         count_r <= load_val;
      end
      else if (tick && (count_r != '0))
      begin
         count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign running = (count_r != '0);

endmodule : ms_timer
`default_nettype wire

// File: bench/trip_logic_monitor.sv
// Port checker for the phase-selective trip logic
`timescale 1ns/100ps
`default_nettype none
module trip_logic_monitor #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [trip_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic trip_suppress_in,
   input wire logic phase_a_request_in,
   input wire logic phase_b_request_in,
   input wire logic phase_c_request_in,
   input wire logic force_three_pole_in,
   input wire logic phase_a_trip_out,
   input wire logic phase_b_trip_out,
   input wire logic phase_c_trip_out,
   input wire logic general_trip_out,
   input wire logic three_pole_trip_out
);
   // ****************************************************************
   // Helper state
   // ****************************************************************
   localparam int MIN_CYC = 50 * TICK_CYCLES;
   logic wr_ctrl;
   logic [1:0] mode_r;
   logic [7:0] hold_r;
   logic [31:0] hi_cnt_r;
   assign wr_ctrl = psel & penable & pready & pwrite & (paddr == trip_pkg::CTRL_OFS);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_r <= trip_pkg::MODE_OFF;
      else if (wr_ctrl && pwdata[1:0] != 2'h3)
         mode_r <= pwdata[1:0];
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold_r <= 8'hFF;
      else
         hold_r <= {hold_r[6:0], trip_suppress_in | (mode_r == trip_pkg::MODE_OFF)
                    | (wr_ctrl & pwdata[trip_pkg::CTRL_CLR_BIT])};
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hi_cnt_r <= 32'h0000_0000;
      else if (general_trip_out)
         hi_cnt_r <= hi_cnt_r + 32'h0000_0001;
      else
         hi_cnt_r <= 32'h0000_0000;
   end
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_supp;
      trip_suppress_in [*6] |-> !(phase_a_trip_out | phase_b_trip_out | phase_c_trip_out
                                  | general_trip_out | three_pole_trip_out);
   endproperty
   a_supp: assert property (p_supp) else $error("trip while suppressed");
   property p_three;
      three_pole_trip_out == (phase_a_trip_out & phase_b_trip_out & phase_c_trip_out);
   endproperty
   a_three: assert property (p_three) else $error("three-pole mismatch");
   property p_gen;
      general_trip_out == (phase_a_trip_out | phase_b_trip_out | phase_c_trip_out);
   endproperty
   a_gen: assert property (p_gen) else $error("general trip mismatch");
   property p_off;
      (mode_r == trip_pkg::MODE_OFF) [*2] |-> !general_trip_out;
   endproperty
   a_off: assert property (p_off) else $error("trip while off");
   property p_pp;
      (mode_r != trip_pkg::MODE_OFF && !trip_suppress_in && phase_a_request_in
       && phase_b_request_in) [*6] |-> phase_c_trip_out;
   endproperty
   a_pp: assert property (p_pp) else $error("third phase missing");
   property p_force;
      (mode_r == trip_pkg::MODE_SELECT && !trip_suppress_in && force_three_pole_in
       && phase_a_request_in) [*6] |-> phase_b_trip_out && phase_c_trip_out;
   endproperty
   a_force: assert property (p_force) else $error("force ignored");
   property p_only3;
      (mode_r == trip_pkg::MODE_THREE && !trip_suppress_in && (phase_a_request_in
       | phase_b_request_in | phase_c_request_in)) [*6] |-> three_pole_trip_out;
   endproperty
   a_only3: assert property (p_only3) else $error("three-only mode partial");
   property p_phase;
      (mode_r != trip_pkg::MODE_OFF && !trip_suppress_in && phase_a_request_in) [*6]
         |-> phase_a_trip_out;
   endproperty
   a_phase: assert property (p_phase) else $error("phase request ignored");
   property p_pulse;
      $fell(general_trip_out) && hold_r == 8'h00 |-> hi_cnt_r >= MIN_CYC;
   endproperty
   a_pulse: assert property (p_pulse) else $error("trip pulse too short");
endmodule : trip_logic_monitor
bind trip_logic trip_logic_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pready(pready),
   .trip_suppress_in(trip_suppress_in),
   .phase_a_request_in(phase_a_request_in),
   .phase_b_request_in(phase_b_request_in),
   .phase_c_request_in(phase_c_request_in),
   .force_three_pole_in(force_three_pole_in),
   .phase_a_trip_out(phase_a_trip_out),
   .phase_b_trip_out(phase_b_trip_out),
   .phase_c_trip_out(phase_c_trip_out),
   .general_trip_out(general_trip_out),
   .three_pole_trip_out(three_pole_trip_out)
);
`default_nettype wire

// File: bench/upstream_model.sv
// Upstream protection request model
`timescale 1ns/100ps
`default_nettype none
module upstream_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic [6:0] pat,
   input wire logic [7:0] len,
   output logic [6:0] req
);
   logic [6:0] pat_r;
   logic [7:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= 8'h00;
      else if (go)
         cnt_r <= len;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pat_r <= 7'h00;
      else if (go)
         pat_r <= pat;
   end
   // Requests held for len cycles, then inactive
   assign req = (cnt_r != 8'h00) ? pat_r : 7'h00;
endmodule : upstream_model
`default_nettype wire

// File: bench/phase_selective_trip_logic_tb.sv
// Self-checking bench of the phase-selective trip logic
`timescale 1ns/100ps
`default_nettype none
module phase_selective_trip_logic_tb;
   localparam int TK = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, er, ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] pat, req;
   logic [7:0] len;
   logic [4:0] tr;
   int bad_count, n_tests, cnt;
   logic [6:0] tp [8] = '{7'h01, 7'h01, 7'h05, 7'h21, 7'h08, 7'h0A, 7'h10, 7'h41};
   logic [1:0] tm [8] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
   logic [4:0] te [8] = '{5'h00, 5'h11, 5'h1F, 5'h1F, 5'h1F, 5'h12, 5'h1F, 5'h00};
   trip_logic #(.TICK_CYCLES(TK)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trip_suppress_in(req[trip_pkg::REQ_SUPP]),
      .single_pole_request_in(req[trip_pkg::REQ_SINGLE]),
      .three_pole_request_in(req[trip_pkg::REQ_THREE]),
      .phase_a_request_in(req[trip_pkg::REQ_A]), .phase_b_request_in(req[trip_pkg::REQ_B]),
      .phase_c_request_in(req[trip_pkg::REQ_C]),
      .force_three_pole_in(req[trip_pkg::REQ_FORCE]),
      .phase_a_trip_out(tr[0]), .phase_b_trip_out(tr[1]), .phase_c_trip_out(tr[2]),
      .three_pole_trip_out(tr[3]), .general_trip_out(tr[4])
   );
   upstream_model far (.pclk(pclk), .presetn(presetn), .go(go), .pat(pat), .len(len),
      .req(req));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests++;
         if (got !== exp)
         begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask : chk_word
   task chk_trip(input logic [4:0] got, input logic [4:0] exp);
      chk_word({27'h000_0000, got}, {27'h000_0000, exp});
   endtask : chk_trip
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do
            @(posedge pclk);
         while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : xfer
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      begin
         xfer(1'b0, a, 32'h0000_0000);
         chk_word(rd, exp);
      end
   endtask : rd_chk
   task fire(input logic [6:0] p);
      begin
         @(posedge pclk);
         go <= 1'b1;
         pat <= p;
         @(posedge pclk);
         go <= 1'b0;
         repeat (8) @(posedge pclk);
         #1;
      end
   endtask : fire
   task wait_low;
      begin
         cnt = 0;
         while (tr[4] !== 1'b0 && cnt < 400)
         begin
            @(posedge pclk);
            #1;
            cnt++;
         end
      end
   endtask : wait_low
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask : wrap_up
   // ****************************************************************
   // Clock, watchdog and tests
   // ****************************************************************
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      wrap_up();
   end
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, go} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pat = 7'h00;
      len = 8'h0A;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(trip_pkg::CTRL_OFS, 32'h0000_0000);
      rd_chk(trip_pkg::PULSE_OFS, 32'h0000_0096);
      rd_chk(trip_pkg::EVOLVE_OFS, 32'h0000_03E8);
      xfer(1'b0, 12'h020, 32'h0000_0000);
      chk_word({rd[30:0], er}, 32'h0000_0001);
      xfer(1'b1, trip_pkg::PULSE_OFS, 32'h0000_0031);
      rd_chk(trip_pkg::PULSE_OFS, 32'h0000_0096);
      xfer(1'b1, trip_pkg::PULSE_OFS, 32'h0000_EA61);
      rd_chk(trip_pkg::PULSE_OFS, 32'h0000_0096);
      xfer(1'b1, trip_pkg::PULSE_OFS, 32'h0000_EA60);
      rd_chk(trip_pkg::PULSE_OFS, 32'h0000_EA60);
      xfer(1'b1, trip_pkg::PULSE_OFS, 32'h0000_0032);
      xfer(1'b1, trip_pkg::EVOLVE_OFS, 32'h0000_0032);
      rd_chk(trip_pkg::EVOLVE_OFS, 32'h0000_0032);
      xfer(1'b1, trip_pkg::CTRL_OFS, 32'h0000_0003);
      rd_chk(trip_pkg::CTRL_OFS, 32'h0000_0000);
      xfer(1'b1, trip_pkg::CTRL_OFS, 32'h0000_0002);
      fire(7'h01);
      wait_low();
      ok = (cnt + 4 > 50 * TK) && (cnt + 4 <= 51 * TK + 2);
      chk_word({31'h0000_0000, ok}, 32'h0000_0001);
      rd_chk(trip_pkg::EVENT_OFS, 32'h0000_0099);
      xfer(1'b1, trip_pkg::EVENT_OFS, 32'h0000_00FF);
      rd_chk(trip_pkg::EVENT_OFS, 32'h0000_0000);
      fire(7'h02);
      chk_trip(tr, 5'h1F);
      xfer(1'b0, trip_pkg::STATUS_OFS, 32'h0000_0000);
      chk_word(rd & 32'h0000_00BF, 32'h0000_003F);
      wait_low();
      repeat (230) @(posedge pclk);
      fire(7'h01);
      repeat (8) @(posedge pclk);
      xfer(1'b1, trip_pkg::CTRL_OFS, 32'h0000_0102);
      repeat (3) @(posedge pclk);
      #1;
      chk_trip(tr, 5'h00);
      rd_chk(trip_pkg::STATUS_OFS, 32'h0000_0000);
      for (int i = 0; i < 8; i++)
      begin
         xfer(1'b1, trip_pkg::CTRL_OFS, {30'h0000_0000, tm[i]});
         fire(tp[i]);
         chk_trip(tr, te[i]);
         wait_low();
         repeat (230) @(posedge pclk);
      end
      xfer(1'b1, trip_pkg::CTRL_OFS, 32'h0000_0001);
      fire(7'h02);
      chk_trip(tr, 5'h1F);
      wrap_up();
   end
endmodule : phase_selective_trip_logic_tb
`default_nettype wire
